// [include/hpgc_pkg.sv]
// Purpose: Shared constants for the headphone gain control register bank.
// Assumes: Register index times four is the AXI4-Lite byte address.
// Notes: Codes and field positions are used by the top and the gate module.
package hpgc_pkg;
  // Register indices
  localparam logic [7:0] IDX_LEFT_GAIN = 8'h02;
  localparam logic [7:0] IDX_RIGHT_GAIN = 8'h03;
  localparam logic [7:0] IDX_TIMEOUT_CFG = 8'h08;
  localparam logic [7:0] IDX_STATUS = 8'h09;
  localparam logic [7:0] IDX_POWER_TWO = 8'h1A;
  localparam logic [7:0] IDX_TRIM = 8'h47;
  localparam logic [7:0] IDX_PUMP = 8'h52;

  // Gain register fields
  localparam int BIT_STROBE = 8;
  localparam int BIT_ZC = 7;
  localparam int CODE_W = 7;
  localparam int CODE_MSB = 6;
  // Power management two fields
  localparam int BIT_MUTE_LEFT = 1;
  localparam int BIT_MUTE_RIGHT = 0;
  // Trim register fields
  localparam int TRIM_W = 3;
  localparam int TRIM_LEFT_LSB = 6;
  localparam int TRIM_RIGHT_LSB = 3;
  // Timeout config fields
  localparam int BIT_TO_ENABLE = 0;
  localparam int TO_DIV_LSB = 1;
  localparam int TO_DIV_W = 3;
  // Pump register field
  localparam int BIT_PUMP_DYN = 0;
  // Status fields
  localparam int ST_RIGHT_LSB = 7;
  localparam int ST_PEND_LEFT = 14;
  localparam int ST_PEND_RIGHT = 15;
  localparam int ST_PUMP_REG = 16;
  localparam int ST_MUTE_LEFT = 17;
  localparam int ST_MUTE_RIGHT = 18;

  // Reset values
  localparam logic [6:0] CODE_RESET = 7'h00;
  localparam logic [2:0] TRIM_RESET = 3'h7;

  // Gain decode points
  localparam logic [6:0] CODE_MUTE_MAX = 7'h2F;
  localparam logic [6:0] CODE_FLOOR_MAX = 7'h35;
  localparam logic [7:0] CODE_ZERO_DB = 8'h79;
  localparam logic [7:0] FLOOR_DB = 8'hBC;  // -68 dB
  localparam logic [7:0] TRIM_ZERO_DB = 8'h07;

  // AXI4-Lite responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// [src/hpgc_zc_gate.sv]
// Purpose: Holds one channel's main gain change until zero cross or timeout.
// Assumes: toTick is already gated by the timeout clock enable.
// Notes: A new load while pending with zero-cross on replaces the code and restarts the timeout.
`timescale 1ns/1ps
module hpgc_zc_gate #(
  parameter int DIV_W = 3,
  parameter int CNT_W = 8
) (
  input wire logic ref_clk, // System clock
  input wire logic srst, // Synchronous reset, active high
  input wire logic load, // Applied update strobe, one cycle
  input wire logic [6:0] newCode, // Stored main gain code
  input wire logic zcEnable, // Zero-cross gating on
  input wire logic zeroCross, // Zero crossing seen this cycle
  input wire logic toTick, // Timeout clock tick
  input wire logic [DIV_W-1:0] toDiv, // Timeout period select
  output logic [6:0] activeCode_ff, // Gain code in effect
  output logic pending_ff // Change waiting for zero cross
);
  logic [6:0] pendCode_ff;
  logic [CNT_W-1:0] tickCnt_ff;
  logic [CNT_W-1:0] target;

  initial begin
    if (CNT_W < (1 << DIV_W)) begin
      $error("hpgc_zc_gate: CNT_W too small for DIV_W");
    end
  end

  // Period doubles with each divider step
  assign target = CNT_W'(1) << toDiv; // [RQ7]

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      activeCode_ff <= hpgc_pkg::CODE_RESET; // [RQ17]
      pendCode_ff <= hpgc_pkg::CODE_RESET;
      pending_ff <= 1'b0;
      tickCnt_ff <= '0;
    end else if (load) begin
      if (!zcEnable) begin
        activeCode_ff <= newCode; // [RQ10]
        pending_ff <= 1'b0;
      end else begin
        pendCode_ff <= newCode; // [RQ5]
        pending_ff <= 1'b1;
        tickCnt_ff <= '0;
      end
    end else if (pending_ff) begin
      // Dropping the enable while pending releases the change at once
      if (!zcEnable || zeroCross) begin
        activeCode_ff <= pendCode_ff; // [RQ5]
        pending_ff <= 1'b0;
      end else if (toTick) begin
        if (tickCnt_ff + CNT_W'(1) >= target) begin
          activeCode_ff <= pendCode_ff; // [RQ6]
          pending_ff <= 1'b0;
        end else begin
          tickCnt_ff <= tickCnt_ff + CNT_W'(1); // [RQ7]
        end
      end
    end
  end
endmodule

// [src/hpgc_top.sv]
// Purpose: Headphone gain control register bank with AXI4-Lite slave.
// Assumes: Zero-cross inputs are synchronous one-cycle detections.
// Notes: Byte address is register index times four; only byte lanes 0..2 matter.
// Function
// [RQ1] Main stage spans -68dB to +6dB in 1dB steps.
// [RQ2] Codes to 0x2F mute, to 0x35 give -68dB, 0x79 is 0dB.
// [RQ3] Trim code 000 is -7dB up to 111 at 0dB, resets to 111.
// [RQ4] Channel total gain is main gain plus trim gain.
// [RQ5] With zero-cross on, a pending main change waits for a crossing.
// [RQ6] Without a crossing, the pending change applies when the timeout expires.
// [RQ7] Timeout counts only when enabled; divider setting selects its period.
// [RQ8] Bit 7 of each gain register enables zero-cross, reset 0.
// [RQ9] Writing a code without strobe stores it, active gain unchanged.
// [RQ10] Strobe bit 8 in either gain register applies both stored codes.
// [RQ11] Stored mutes take effect only on the update strobe.
// [RQ12] Mute bit 1 left, bit 0 right; 1 mutes; reset un-muted.
// [RQ13] Trim codes act at once, independent of the strobe.
// [RQ14] Trim changes bypass zero-cross gating.
// [RQ15] Software changes only main gains during playback.
// [RQ16] Software should set both trim codes to 000.
// [RQ17] Main gain codes reset to zero, leaving the channel muted.
// [RQ18] Selecting register pump mode completes only on the update strobe.
// [RQ19] Update strobe self-clears, is not stored, reads as zero.
`timescale 1ns/1ps
module hpgc_top #(
  parameter int ADDR_W = 10,
  parameter int TICK_CYCLES = 1000
) (
  input wire logic ref_clk, // 20 MHz system clock
  input wire logic srst, // Synchronous reset, active high
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [ADDR_W-1:0] s_axi_awaddr, // Write byte address
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write byte enables
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  output logic [1:0] s_axi_bresp, // Write response
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  input wire logic [ADDR_W-1:0] s_axi_araddr, // Read byte address
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  input wire logic leftZeroCross, // Left signal zero crossing
  input wire logic rightZeroCross, // Right signal zero crossing
  output logic [6:0] leftActiveCode, // Left main code in effect
  output logic [6:0] rightActiveCode, // Right main code in effect
  output logic leftMuted, // Left main stage silent
  output logic rightMuted, // Right main stage silent
  output logic [2:0] leftTrimCode, // Left trim code in effect
  output logic [2:0] rightTrimCode, // Right trim code in effect
  output logic [7:0] leftTotalGainDb, // Left total gain, signed dB
  output logic [7:0] rightTotalGainDb, // Right total gain, signed dB
  output logic pumpRegisterMode // Pump under register control
);
  localparam int TICK_W = $clog2(TICK_CYCLES + 1);

  initial begin
    if (ADDR_W < 10 || TICK_CYCLES < 1) begin
      $error("hpgc_top: ADDR_W must be at least 10 and TICK_CYCLES at least 1");
    end
  end

  // Main stage gain in dB, signed 8 bits
  function automatic logic [7:0] mainDb(input logic [6:0] code);
    if (code <= hpgc_pkg::CODE_FLOOR_MAX) begin
      mainDb = hpgc_pkg::FLOOR_DB; // [RQ2]
    end else begin
      mainDb = {1'b0, code} - hpgc_pkg::CODE_ZERO_DB; // [RQ1]
    end
  endfunction

  function automatic logic [7:0] trimDb(input logic [2:0] code);
    trimDb = {5'h00, code} - hpgc_pkg::TRIM_ZERO_DB; // [RQ3]
  endfunction

  function automatic logic codeMutes(input logic [6:0] code);
    codeMutes = (code <= hpgc_pkg::CODE_MUTE_MAX); // [RQ2]
  endfunction

  // Stored register contents
  logic [6:0] leftCode_ff;
  logic [6:0] rightCode_ff;
  logic leftZc_ff;
  logic rightZc_ff;
  logic leftMuteStored_ff;
  logic rightMuteStored_ff;
  logic leftMuteActive_ff;
  logic rightMuteActive_ff;
  logic [2:0] leftTrim_ff;
  logic [2:0] rightTrim_ff;
  logic toEnable_ff;
  logic [2:0] toDiv_ff;
  logic pumpDyn_ff;
  logic updPulse_ff;
  logic [TICK_W-1:0] preCnt_ff;
  logic toTick_ff;

  // Bus state
  logic awHeld_ff;
  logic wHeld_ff;
  logic [7:0] wIdx_ff;
  logic [31:0] wData_ff;
  logic [3:0] wStrb_ff;
  logic doWrite;
  logic [7:0] rIdx;

  logic [6:0] leftGateCode;
  logic [6:0] rightGateCode;
  logic leftPend;
  logic rightPend;

  assign doWrite = awHeld_ff && wHeld_ff && !s_axi_bvalid;
  assign rIdx = s_axi_araddr[9:2];

  // Write address and data captured independently, in either order
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      awHeld_ff <= 1'b0;
      s_axi_awready <= 1'b0;
      wIdx_ff <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      awHeld_ff <= 1'b1;
      s_axi_awready <= 1'b0;
      wIdx_ff <= s_axi_awaddr[9:2];
    end else if (doWrite) begin
      awHeld_ff <= 1'b0;
    end else if (!awHeld_ff && !s_axi_bvalid) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      wHeld_ff <= 1'b0;
      s_axi_wready <= 1'b0;
      wData_ff <= 32'h0000_0000;
      wStrb_ff <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      wHeld_ff <= 1'b1;
      s_axi_wready <= 1'b0;
      wData_ff <= s_axi_wdata;
      wStrb_ff <= s_axi_wstrb;
    end else if (doWrite) begin
      wHeld_ff <= 1'b0;
    end else if (!wHeld_ff && !s_axi_bvalid) begin
      s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= hpgc_pkg::RESP_OKAY;
    end else if (doWrite) begin
      s_axi_bvalid <= 1'b1;
      unique case (wIdx_ff)
        hpgc_pkg::IDX_LEFT_GAIN, hpgc_pkg::IDX_RIGHT_GAIN, hpgc_pkg::IDX_POWER_TWO,
        hpgc_pkg::IDX_TRIM, hpgc_pkg::IDX_PUMP, hpgc_pkg::IDX_TIMEOUT_CFG,
        hpgc_pkg::IDX_STATUS: begin
          s_axi_bresp <= hpgc_pkg::RESP_OKAY;
        end
        default: begin
          s_axi_bresp <= hpgc_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Main gain registers; the strobe is a pulse, never stored
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      leftCode_ff <= hpgc_pkg::CODE_RESET; // [RQ17]
      rightCode_ff <= hpgc_pkg::CODE_RESET; // [RQ17]
      leftZc_ff <= 1'b0; // [RQ8]
      rightZc_ff <= 1'b0; // [RQ8]
      updPulse_ff <= 1'b0;
    end else begin
      updPulse_ff <= 1'b0; // [RQ19]
      if (doWrite && (wIdx_ff == hpgc_pkg::IDX_LEFT_GAIN)) begin
        if (wStrb_ff[0]) begin
          leftCode_ff <= wData_ff[hpgc_pkg::CODE_MSB:0]; // [RQ9]
          leftZc_ff <= wData_ff[hpgc_pkg::BIT_ZC]; // [RQ8]
        end
        if (wStrb_ff[1] && wData_ff[hpgc_pkg::BIT_STROBE]) begin
          updPulse_ff <= 1'b1; // [RQ10]
        end
      end
      if (doWrite && (wIdx_ff == hpgc_pkg::IDX_RIGHT_GAIN)) begin
        if (wStrb_ff[0]) begin
          rightCode_ff <= wData_ff[hpgc_pkg::CODE_MSB:0]; // [RQ9]
          rightZc_ff <= wData_ff[hpgc_pkg::BIT_ZC]; // [RQ8]
        end
        if (wStrb_ff[1] && wData_ff[hpgc_pkg::BIT_STROBE]) begin
          updPulse_ff <= 1'b1; // [RQ10]
        end
      end
    end
  end

  // Mute settings are staged and only applied on the strobe
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      leftMuteStored_ff <= 1'b0; // [RQ12]
      rightMuteStored_ff <= 1'b0; // [RQ12]
      leftMuteActive_ff <= 1'b0;
      rightMuteActive_ff <= 1'b0;
    end else begin
      if (doWrite && (wIdx_ff == hpgc_pkg::IDX_POWER_TWO) && wStrb_ff[0]) begin
        leftMuteStored_ff <= wData_ff[hpgc_pkg::BIT_MUTE_LEFT]; // [RQ12]
        rightMuteStored_ff <= wData_ff[hpgc_pkg::BIT_MUTE_RIGHT]; // [RQ12]
      end
      if (updPulse_ff) begin
        leftMuteActive_ff <= leftMuteStored_ff; // [RQ11]
        rightMuteActive_ff <= rightMuteStored_ff; // [RQ11]
      end
    end
  end

  // Trim codes drive the outputs directly, no strobe and no gating
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      leftTrim_ff <= hpgc_pkg::TRIM_RESET; // [RQ3]
      rightTrim_ff <= hpgc_pkg::TRIM_RESET; // [RQ3]
    end else if (doWrite && (wIdx_ff == hpgc_pkg::IDX_TRIM)) begin
      if (wStrb_ff[1]) begin
        leftTrim_ff <= wData_ff[hpgc_pkg::TRIM_LEFT_LSB +: hpgc_pkg::TRIM_W]; // [RQ13]
      end
      if (wStrb_ff[0]) begin
        rightTrim_ff <= wData_ff[hpgc_pkg::TRIM_RIGHT_LSB +: hpgc_pkg::TRIM_W]; // [RQ13]
      end
    end
  end

  // Timeout config and pump mode
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      toEnable_ff <= 1'b0;
      toDiv_ff <= 3'h0;
      pumpDyn_ff <= 1'b0;
      pumpRegisterMode <= 1'b1;
    end else begin
      if (doWrite && (wIdx_ff == hpgc_pkg::IDX_TIMEOUT_CFG) && wStrb_ff[0]) begin
        toEnable_ff <= wData_ff[hpgc_pkg::BIT_TO_ENABLE];
        toDiv_ff <= wData_ff[hpgc_pkg::TO_DIV_LSB +: hpgc_pkg::TO_DIV_W];
      end
      if (doWrite && (wIdx_ff == hpgc_pkg::IDX_PUMP) && wStrb_ff[0]) begin
        pumpDyn_ff <= wData_ff[hpgc_pkg::BIT_PUMP_DYN];
        // Dynamic mode takes over at once; register mode waits for the strobe
        if (wData_ff[hpgc_pkg::BIT_PUMP_DYN]) begin
          pumpRegisterMode <= 1'b0;
        end
      end else if (updPulse_ff && !pumpDyn_ff) begin
        pumpRegisterMode <= 1'b1; // [RQ18]
      end
    end
  end

  // Timeout prescaler runs only while enabled, so a stopped clock never expires
  always_ff @(posedge ref_clk) begin
    if (srst || !toEnable_ff) begin
      preCnt_ff <= '0;
      toTick_ff <= 1'b0;
    end else if (preCnt_ff == TICK_W'(TICK_CYCLES - 1)) begin
      preCnt_ff <= '0;
      toTick_ff <= 1'b1; // [RQ7]
    end else begin
      preCnt_ff <= preCnt_ff + TICK_W'(1);
      toTick_ff <= 1'b0;
    end
  end

  hpgc_zc_gate #(.DIV_W(hpgc_pkg::TO_DIV_W), .CNT_W(8)) leftGate (
    .ref_clk(ref_clk),
    .srst(srst),
    .load(updPulse_ff),
    .newCode(leftCode_ff),
    .zcEnable(leftZc_ff),
    .zeroCross(leftZeroCross),
    .toTick(toTick_ff),
    .toDiv(toDiv_ff),
    .activeCode_ff(leftGateCode),
    .pending_ff(leftPend)
  );

  hpgc_zc_gate #(.DIV_W(hpgc_pkg::TO_DIV_W), .CNT_W(8)) rightGate (
    .ref_clk(ref_clk),
    .srst(srst),
    .load(updPulse_ff),
    .newCode(rightCode_ff),
    .zcEnable(rightZc_ff),
    .zeroCross(rightZeroCross),
    .toTick(toTick_ff),
    .toDiv(toDiv_ff),
    .activeCode_ff(rightGateCode),
    .pending_ff(rightPend)
  );

  // Outputs re-registered one cycle after the gate and trim state
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      leftActiveCode <= hpgc_pkg::CODE_RESET;
      rightActiveCode <= hpgc_pkg::CODE_RESET;
      leftMuted <= 1'b1;
      rightMuted <= 1'b1;
      leftTrimCode <= hpgc_pkg::TRIM_RESET;
      rightTrimCode <= hpgc_pkg::TRIM_RESET;
      leftTotalGainDb <= hpgc_pkg::FLOOR_DB;
      rightTotalGainDb <= hpgc_pkg::FLOOR_DB;
    end else begin
      leftActiveCode <= leftGateCode;
      rightActiveCode <= rightGateCode;
      leftMuted <= codeMutes(leftGateCode) || leftMuteActive_ff; // [RQ2]
      rightMuted <= codeMutes(rightGateCode) || rightMuteActive_ff; // [RQ2]
      leftTrimCode <= leftTrim_ff; // [RQ14]
      rightTrimCode <= rightTrim_ff; // [RQ14]
      leftTotalGainDb <= mainDb(leftGateCode) + trimDb(leftTrim_ff); // [RQ4]
      rightTotalGainDb <= mainDb(rightGateCode) + trimDb(rightTrim_ff); // [RQ4]
    end
  end

  // Read channel; strobe bit always reads zero
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= hpgc_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= hpgc_pkg::RESP_OKAY;
      unique case (rIdx)
        hpgc_pkg::IDX_LEFT_GAIN: begin
          s_axi_rdata[hpgc_pkg::BIT_ZC:0] <= {leftZc_ff, leftCode_ff}; // [RQ19]
        end
        hpgc_pkg::IDX_RIGHT_GAIN: begin
          s_axi_rdata[hpgc_pkg::BIT_ZC:0] <= {rightZc_ff, rightCode_ff}; // [RQ19]
        end
        hpgc_pkg::IDX_POWER_TWO: begin
          s_axi_rdata[hpgc_pkg::BIT_MUTE_LEFT] <= leftMuteStored_ff;
          s_axi_rdata[hpgc_pkg::BIT_MUTE_RIGHT] <= rightMuteStored_ff;
        end
        hpgc_pkg::IDX_TRIM: begin
          s_axi_rdata[hpgc_pkg::TRIM_LEFT_LSB +: hpgc_pkg::TRIM_W] <= leftTrim_ff;
          s_axi_rdata[hpgc_pkg::TRIM_RIGHT_LSB +: hpgc_pkg::TRIM_W] <= rightTrim_ff;
        end
        hpgc_pkg::IDX_PUMP: begin
          s_axi_rdata[hpgc_pkg::BIT_PUMP_DYN] <= pumpDyn_ff;
        end
        hpgc_pkg::IDX_TIMEOUT_CFG: begin
          s_axi_rdata[hpgc_pkg::BIT_TO_ENABLE] <= toEnable_ff;
          s_axi_rdata[hpgc_pkg::TO_DIV_LSB +: hpgc_pkg::TO_DIV_W] <= toDiv_ff;
        end
        hpgc_pkg::IDX_STATUS: begin
          s_axi_rdata[hpgc_pkg::CODE_MSB:0] <= leftGateCode;
          s_axi_rdata[hpgc_pkg::ST_RIGHT_LSB +: hpgc_pkg::CODE_W] <= rightGateCode;
          s_axi_rdata[hpgc_pkg::ST_PEND_LEFT] <= leftPend;
          s_axi_rdata[hpgc_pkg::ST_PEND_RIGHT] <= rightPend;
          s_axi_rdata[hpgc_pkg::ST_PUMP_REG] <= pumpRegisterMode;
          s_axi_rdata[hpgc_pkg::ST_MUTE_LEFT] <= leftMuteActive_ff;
          s_axi_rdata[hpgc_pkg::ST_MUTE_RIGHT] <= rightMuteActive_ff;
        end
        default: begin
          s_axi_rresp <= hpgc_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end else begin
      s_axi_arready <= 1'b1;
    end
  end
endmodule

// [test/hpgc_top_assertions.sv]
// Purpose: Port-level checks for hpgc_top.
// Assumes: Write address and write data are offered in the same cycle.
// Notes: Stable-code guards allow one cycle of output lag.
`timescale 1ns/1ps
module hpgc_top_assertions #(
  parameter int ADDR_W = 10
) (
  input wire logic ref_clk, // Clock
  input wire logic srst, // Reset
  input wire logic s_axi_awvalid, // In
  input wire logic s_axi_awready, // Out
  input wire logic [ADDR_W-1:0] s_axi_awaddr, // In
  input wire logic s_axi_wvalid, // In
  input wire logic s_axi_wready, // Out
  input wire logic [31:0] s_axi_wdata, // In
  input wire logic s_axi_bvalid, // Out
  input wire logic s_axi_bready, // In
  input wire logic [1:0] s_axi_bresp, // Out
  input wire logic s_axi_arvalid, // In
  input wire logic s_axi_arready, // Out
  input wire logic s_axi_rvalid, // Out
  input wire logic [6:0] leftActiveCode, // Out
  input wire logic leftMuted, // Out
  input wire logic [2:0] leftTrimCode, // Out
  input wire logic [7:0] leftTotalGainDb, // Out
  input wire logic pumpRegisterMode // Out
);
  logic [2:0] trimSeen_ff;
  logic [3:0] strobeAge_ff;
  logic wrTaken;
  logic [7:0] wrIdx;
  assign wrTaken = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  assign wrIdx = s_axi_awaddr[9:2];
  function automatic logic [7:0] dbOf(input logic [6:0] c, input logic [2:0] t);
    dbOf = ((c <= 7'h35) ? 8'hBC : ({1'b0, c} - 8'h79)) + {5'h00, t} - 8'h07;
  endfunction
  always_ff @(posedge ref_clk) begin
    if (wrTaken && wrIdx == hpgc_pkg::IDX_TRIM) trimSeen_ff <= s_axi_wdata[8:6];
  end
  // Strobe write age, ties a later mode change to it
  always_ff @(posedge ref_clk) begin
    if (srst) strobeAge_ff <= 4'h0;
    else if (wrTaken && s_axi_wdata[8] && (wrIdx == 8'h02 || wrIdx == 8'h03)) strobeAge_ff <= 4'h8;
    else if (strobeAge_ff != 4'h0) strobeAge_ff <= strobeAge_ff - 4'h1;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  a_mute_low_code: assert property (
    $stable(leftActiveCode) && leftActiveCode <= 7'h2F |-> leftMuted)
    else $error("low gain code not muted");
  a_gain_series_sum: assert property (
    $stable(leftActiveCode) && $stable(leftTrimCode) |->
    leftTotalGainDb == dbOf(leftActiveCode, leftTrimCode))
    else $error("total gain not main plus trim");
  a_reset_state: assert property (
    $fell(srst) |-> leftTrimCode == 3'h7 && leftActiveCode == 7'h00 && leftMuted)
    else $error("reset state wrong");
  a_write_answer: assert property (wrTaken |-> ##[1:4] s_axi_bvalid)
    else $error("write response missing");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  a_trim_direct: assert property (
    wrTaken && wrIdx == hpgc_pkg::IDX_TRIM |-> ##[2:4] leftTrimCode == trimSeen_ff)
    else $error("trim not applied directly");
  a_pump_on_strobe: assert property (
    $rose(pumpRegisterMode) |-> strobeAge_ff != 4'h0)
    else $error("pump mode changed without strobe");
endmodule
bind hpgc_top hpgc_top_assertions #(.ADDR_W(ADDR_W)) chk (.*);

// [test/testbench.sv]
// Purpose: Self-checking bench for hpgc_top over AXI4-Lite.
// Assumes: Timeout tick every 2 clocks.
// Notes: Fixed idle waits cover strobe-to-output latency.
`timescale 1ns/1ps
module testbench;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [9:0] s_axi_awaddr = 10'h000, s_axi_araddr = 10'h000;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic leftZeroCross = 1'b0, rightZeroCross = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp, rresp;
  logic [31:0] s_axi_rdata, rd;
  logic [6:0] leftActiveCode, rightActiveCode;
  logic leftMuted, rightMuted, pumpRegisterMode;
  logic [2:0] leftTrimCode, rightTrimCode;
  logic [7:0] leftTotalGainDb, rightTotalGainDb;
  int errTotal = 0;
  int samplesChecked = 0;
  localparam logic [7:0] LG = hpgc_pkg::IDX_LEFT_GAIN, RG = hpgc_pkg::IDX_RIGHT_GAIN;
  localparam logic [7:0] PT = hpgc_pkg::IDX_POWER_TWO, TR = hpgc_pkg::IDX_TRIM;
  hpgc_top #(.ADDR_W(10), .TICK_CYCLES(2)) uut (.ref_clk(ref_clk), .srst(srst),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .leftZeroCross(leftZeroCross),
    .rightZeroCross(rightZeroCross), .leftActiveCode(leftActiveCode),
    .rightActiveCode(rightActiveCode), .leftMuted(leftMuted), .rightMuted(rightMuted),
    .leftTrimCode(leftTrimCode), .rightTrimCode(rightTrimCode),
    .leftTotalGainDb(leftTotalGainDb), .rightTotalGainDb(rightTotalGainDb),
    .pumpRegisterMode(pumpRegisterMode));
  initial begin
    forever #25 ref_clk = ~ref_clk;
  end
  function automatic logic [7:0] dbOf(input logic [6:0] c, input logic [2:0] t);
    dbOf = ((c <= 7'h35) ? 8'hBC : ({1'b0, c} - 8'h79)) + {5'h00, t} - 8'h07;
  endfunction
  task automatic chk(input string what, input logic [33:0] exp, input logic [33:0] got);
    samplesChecked++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
      errTotal++;
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    s_axi_awaddr <= {idx, 2'h0};
    s_axi_wdata <= d;
    for (n = 0; n < 100; n++) begin
      @(posedge ref_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (n == 100) chk("write answer", 1, 0);
  endtask
  task automatic rdReg(input logic [7:0] idx);
    int n;
    @(posedge ref_clk);
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    s_axi_araddr <= {idx, 2'h0};
    for (n = 0; n < 100; n++) begin
      @(posedge ref_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    rd = s_axi_rdata;
    rresp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (n == 100) chk("read answer", 1, 0);
  endtask
  task automatic t_reset;
    chk("codes", 0, {leftActiveCode, rightActiveCode});
    chk("mutes", 2'h3, {leftMuted, rightMuted});
    chk("trims", 6'h3F, {leftTrimCode, rightTrimCode});
    chk("gains", 16'hBCBC, {leftTotalGainDb, rightTotalGainDb});
    rdReg(LG);
    chk("left gain reg", 0, rd);
    rdReg(PT);
    chk("power two reg", 0, rd);
    rdReg(TR);
    chk("trim reg", 32'h1F8, rd);
  endtask
  task automatic t_stage;
    wr(LG, 32'h79);
    wr(RG, 32'h40);
    wr(PT, 32'h1);
    idle(6);
    chk("staged code", 0, leftActiveCode);
    wr(RG, 32'h140);
    idle(6);
    chk("both applied", 14'h3CC0, {leftActiveCode, rightActiveCode});
    chk("mute applied", 2'h1, {leftMuted, rightMuted});
    wr(PT, 32'h2);
    idle(6);
    chk("mute held", 2'h1, {leftMuted, rightMuted});
    wr(LG, 32'h179);
    idle(6);
    chk("mute moved", 2'h2, {leftMuted, rightMuted});
    rdReg(LG);
    chk("strobe reads zero", 32'h79, rd);
  endtask
  task automatic t_decode;
    logic [6:0] codes[6] = '{7'h2F, 7'h30, 7'h35, 7'h36, 7'h79, 7'h7F};
    wr(PT, 32'h0);
    for (int i = 0; i < 6; i++) begin
      wr(TR, {23'h0, 3'(i), 3'(5 - i), 3'h0});
      wr(LG, {25'h2, codes[i]});
      idle(6);
      chk("left total", dbOf(codes[i], 3'(i)), leftTotalGainDb);
      chk("right total", dbOf(7'h40, 3'(5 - i)), rightTotalGainDb);
      chk("left mute", codes[i] <= 7'h2F, leftMuted);
    end
  endtask
  task automatic t_trim;
    wr(LG, 32'hE0);
    wr(TR, 32'h0B0);
    idle(2);
    chk("trim direct", 6'h16, {leftTrimCode, rightTrimCode});
    chk("main untouched", 7'h7F, leftActiveCode);
    wr(TR, 32'h0);
  endtask
  task automatic t_zero_cross;
    wr(hpgc_pkg::IDX_TIMEOUT_CFG, 32'h0);
    wr(RG, 32'h65);
    wr(LG, 32'h1D0);
    idle(40);
    chk("right ungated", 7'h65, rightActiveCode);
    chk("left waits", 7'h7F, leftActiveCode);
    rdReg(hpgc_pkg::IDX_STATUS);
    chk("pending", 1, rd[14]);
    @(posedge ref_clk) leftZeroCross <= 1'b1;
    @(posedge ref_clk) leftZeroCross <= 1'b0;
    idle(4);
    chk("crossing applies", 7'h50, leftActiveCode);
    wr(hpgc_pkg::IDX_TIMEOUT_CFG, 32'h7);
    wr(LG, 32'h1D8);
    chk("before timeout", 7'h50, leftActiveCode);
    idle(40);
    chk("timeout applies", 7'h58, leftActiveCode);
  endtask
  task automatic t_pump;
    wr(hpgc_pkg::IDX_PUMP, 32'h1);
    idle(3);
    chk("dynamic at once", 0, pumpRegisterMode);
    wr(hpgc_pkg::IDX_PUMP, 32'h0);
    idle(6);
    chk("register waits", 0, pumpRegisterMode);
    wr(LG, 32'h158);
    idle(6);
    chk("register on strobe", 1, pumpRegisterMode);
  endtask
  task automatic t_unmapped;
    wr(8'h10, 32'h1FF);
    chk("unmapped write", hpgc_pkg::RESP_SLVERR, resp);
    rdReg(8'h10);
    chk("unmapped read", {hpgc_pkg::RESP_SLVERR, 32'h0}, {rresp, rd});
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", samplesChecked, errTotal);
    if (errTotal == 0 && samplesChecked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge ref_clk);
    srst <= 1'b0;
    idle(2);
    t_reset();
    t_stage();
    t_decode();
    t_trim();
    t_zero_cross();
    t_pump();
    t_unmapped();
    final_report();
  end
  // The whole sequence needs about 320 cycles
  initial begin
    repeat (8000) @(posedge ref_clk);
    errTotal++;
    final_report();
  end
endmodule
